// ---- ttp_timeout_protect.sv ----
// transmitter timeout watchdogs, their self-test and the config register
`include "ttp_consts.svh"
// Functional notes
// - each transmitter's watchdog ends any continuous transmission at 663 us.
// - completed arming sets pending flag bit 14 until the test starts.
// - armed test sends 35 counting words, 700 us, so the watchdog cuts.
// - watchdog cut of the test sets loopback fail pending if enabled.
// - trigger bit 15 always reads zero; any register read clears it.
// - pending flag clears itself when the armed transmission begins.
// - part identifier bits 13-12 and revision bits 11-8 read fixed values.
// - with timeout flag enable bit 3 set, a timeout sets terminal flag.
module ttp_timeout_protect
	import ttp_pkg::*;
#(
	parameter int WDT_CYCLES = `TTP_WDT_LIMIT_US * `TTP_CLK_MHZ
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic test_pin,
	input wire logic reg_access,
	input wire logic reg_write,
	input wire logic [7:0] reg_addr,
	input wire ttp_pkg::ttp_word_t reg_wdata,
	output ttp_pkg::ttp_word_t reg_rdata,
	output logic reg_rvalid,
	input wire logic tx_start_a,
	input wire logic tx_start_b,
	input wire logic tx_busy_a,
	input wire logic tx_busy_b,
	input wire logic lb_fail_irq_en_a,
	input wire logic lb_fail_irq_en_b,
	output logic tx_cut_a,
	output logic tx_cut_b,
	output logic test_active,
	output logic test_bus_b,
	output logic test_word_strobe,
	output ttp_pkg::ttp_word_t test_word_data,
	output logic lb_fail_set_a,
	output logic lb_fail_set_b,
	output logic terminal_flag_set
);
	import ttp_pkg::*;

	localparam logic [11:0] WORD_CYCLES =
		12'(`TTP_WORD_TIME_US * `TTP_CLK_MHZ);

	logic test_pin_meta_reg;
	logic test_pin_reg;
	logic trigger_reg;
	logic pending_reg;
	logic tfe_reg;
	ttp_seq_e seq_reg;
	logic [11:0] tick_reg;
	logic [5:0] words_reg;
	logic timeout_a;
	logic timeout_b;
	logic hit;
	logic rd_hit;
	logic wr_hit;
	logic arm_done;
	logic test_start;
	logic sel_cut;
	logic last_tick;

	// ==========================================================
	// helpers
	function automatic ttp_word_t compose_read(input logic pend,
		input logic tfe);
		ttp_word_t w;
		w = 16'h0;
		w[`TTP_PENDING_BIT] = pend;
		w[`TTP_PART_ID_HI:`TTP_PART_ID_LO] = `TTP_PART_ID_VAL;
		w[`TTP_REV_HI:`TTP_REV_LO] = `TTP_REV_VAL;
		w[`TTP_TFE_BIT] = tfe;
		return w;
	endfunction : compose_read

	// ==========================================================
	// watchdogs, one per bus
	ttp_tx_watchdog #(.LIMIT_CYCLES(WDT_CYCLES)) u_wdt_a (
		.clk(clk),
		.reset_n(reset_n),
		.tx_busy(tx_busy_a),
		.tx_cut(tx_cut_a),
		.timeout(timeout_a)
	);
	ttp_tx_watchdog #(.LIMIT_CYCLES(WDT_CYCLES)) u_wdt_b (
		.clk(clk),
		.reset_n(reset_n),
		.tx_busy(tx_busy_b),
		.tx_cut(tx_cut_b),
		.timeout(timeout_b)
	);

	// ==========================================================
	// test pin synchroniser, the pin is asynchronous to clk
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			test_pin_meta_reg <= 1'b0;
			test_pin_reg <= 1'b0;
		end else begin
			test_pin_meta_reg <= test_pin;
			test_pin_reg <= test_pin_meta_reg;
		end
	end

	// ==========================================================
	// decode
	assign hit = reg_access && reg_addr == `TTP_MCFG2_OFFSET;
	assign rd_hit = hit && !reg_write;
	assign wr_hit = hit && reg_write;
	// second step: the very next access, a write of zero to bit 15
	assign arm_done = trigger_reg && wr_hit
		&& !reg_wdata[`TTP_TRIGGER_BIT];
	assign test_start = seq_reg == TTP_SEQ_IDLE && pending_reg
		&& (tx_start_a || tx_start_b);
	assign sel_cut = test_bus_b ? tx_cut_b : tx_cut_a;
	assign last_tick = tick_reg == WORD_CYCLES - 12'h1;

	// ==========================================================
	// arming: first half of the sequence
	// any other access in between aborts, so a stray write cannot arm
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			trigger_reg <= 1'b0;
		end else if (reg_access) begin
			if (rd_hit) begin
				trigger_reg <= 1'b0;
			end else if (!trigger_reg && wr_hit) begin
				trigger_reg <= reg_wdata[`TTP_TRIGGER_BIT]
					&& test_pin_reg;
			end else begin
				trigger_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// pending flag: arming wins over the automatic clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pending_reg <= `TTP_PENDING_RESET;
		end else if (arm_done) begin
			pending_reg <= 1'b1;
		end else if (test_start) begin
			pending_reg <= 1'b0;
		end
	end

	// ==========================================================
	// writable control and read data
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tfe_reg <= `TTP_TFE_RESET;
			reg_rdata <= 16'h0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= rd_hit;
			if (wr_hit) begin
				tfe_reg <= reg_wdata[`TTP_TFE_BIT];
			end
			if (rd_hit) begin
				reg_rdata <= compose_read(pending_reg, tfe_reg);
			end
		end
	end

	// ==========================================================
	// test sequencer: counting words, one per word time
	// the watchdog is expected to stop it before the last word
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			seq_reg <= TTP_SEQ_IDLE;
			tick_reg <= 12'h0;
			words_reg <= 6'h0;
			test_active <= 1'b0;
			test_bus_b <= 1'b0;
			test_word_strobe <= 1'b0;
			test_word_data <= 16'h0;
		end else begin
			unique case (seq_reg)
				TTP_SEQ_IDLE: begin
					test_word_strobe <= 1'b0;
					if (test_start) begin
						seq_reg <= TTP_SEQ_SEND;
						test_active <= 1'b1;
						test_bus_b <= !tx_start_a;
						tick_reg <= 12'h0;
						words_reg <= 6'h1;
						test_word_strobe <= 1'b1;
						test_word_data <= 16'h0;
					end
				end
				TTP_SEQ_SEND: begin
					test_word_strobe <= 1'b0;
					tick_reg <= last_tick ? 12'h0 : tick_reg + 12'h1;
					if (sel_cut) begin
						seq_reg <= TTP_SEQ_IDLE;
						test_active <= 1'b0;
					end else if (last_tick) begin
						if (words_reg == `TTP_TEST_WORDS) begin
							seq_reg <= TTP_SEQ_IDLE;
							test_active <= 1'b0;
						end else begin
							words_reg <= words_reg + 6'h1;
							test_word_strobe <= 1'b1;
							test_word_data <= test_word_data + 16'h1;
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// event pulses to the interrupt and status word logic
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			lb_fail_set_a <= 1'b0;
			lb_fail_set_b <= 1'b0;
			terminal_flag_set <= 1'b0;
		end else begin
			lb_fail_set_a <= test_active && !test_bus_b && timeout_a
				&& lb_fail_irq_en_a;
			lb_fail_set_b <= test_active && test_bus_b && timeout_b
				&& lb_fail_irq_en_b;
			terminal_flag_set <= tfe_reg
				&& (timeout_a || timeout_b);
		end
	end

	// ==========================================================
	// checks
	a_trigger_reads_zero: assert property (@(posedge clk) disable iff (!reset_n)
		rd_hit |=> reg_rvalid && !reg_rdata[15] && !trigger_reg)
		else $error("trigger bit not zero after read");
	a_ident_fields: assert property (@(posedge clk) disable iff (!reset_n)
		reg_rvalid |-> reg_rdata[13:12] == `TTP_PART_ID_VAL
			&& reg_rdata[11:8] == `TTP_REV_VAL)
		else $error("identification fields wrong");
	a_arm_sets_pending: assert property (@(posedge clk) disable iff (!reset_n)
		arm_done |=> pending_reg)
		else $error("pending not set after arming");
	a_pin_gates_arm: assert property (@(posedge clk) disable iff (!reset_n)
		!trigger_reg && wr_hit && !test_pin_reg |=> !trigger_reg)
		else $error("armed without test pin");
	a_pending_clears: assert property (@(posedge clk) disable iff (!reset_n)
		test_start && !arm_done |=> !pending_reg && test_active
			&& test_word_strobe)
		else $error("pending not cleared at test start");
	a_word_spacing: assert property (@(posedge clk) disable iff (!reset_n)
		test_word_strobe && test_active |=> !test_word_strobe [*8])
		else $error("test words too close");
	a_loopback_fail: assert property (@(posedge clk) disable iff (!reset_n)
		test_active && !test_bus_b && timeout_a && lb_fail_irq_en_a
			|=> lb_fail_set_a ##1 !test_active)
		else $error("loopback fail not flagged on cut");
	a_terminal_flag: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(tx_cut_a) && tfe_reg |=> terminal_flag_set)
		else $error("terminal flag not set on timeout");
endmodule : ttp_timeout_protect

// ---- ttp_consts.svh ----
// constants for the transmitter timeout protection and its self-test
`ifndef TTP_CONSTS_SVH
`define TTP_CONSTS_SVH

// ==========================================================
// register map
`define TTP_MCFG2_OFFSET 8'h4e
`define TTP_TRIGGER_BIT 15
`define TTP_PENDING_BIT 14
`define TTP_PART_ID_HI 13
`define TTP_PART_ID_LO 12
`define TTP_REV_HI 11
`define TTP_REV_LO 8
`define TTP_TFE_BIT 3
`define TTP_TFE_RESET 1'b0
`define TTP_PENDING_RESET 1'b0
// identity values are arbitrary
`define TTP_PART_ID_VAL 2'h2
`define TTP_REV_VAL 4'h5

// ==========================================================
// timing
`define TTP_CLK_MHZ 100
`define TTP_WDT_LIMIT_US 663
`define TTP_WORD_TIME_US 20
`define TTP_TEST_WORDS 6'h23
`define TTP_TEST_TIME_US 700

`endif

// ---- ttp_pkg.sv ----
// types shared by the timeout protection block
package ttp_pkg;
	// test sequencer states
	typedef enum logic [1:0] {
		TTP_SEQ_IDLE = 2'b00,
		TTP_SEQ_SEND = 2'b01
	} ttp_seq_e;
	typedef logic [15:0] ttp_word_t;
endpackage : ttp_pkg

// ---- ttp_tx_watchdog.sv ----
// per-transmitter continuous transmission watchdog
`include "ttp_consts.svh"
module ttp_tx_watchdog #(
	parameter int LIMIT_CYCLES = `TTP_WDT_LIMIT_US * `TTP_CLK_MHZ
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic tx_busy,
	output logic tx_cut,
	output logic timeout
);
	logic [16:0] cnt_reg;
	logic [16:0] cnt_next;

	// ==========================================================
	// duration counter
	// restarts every time the line goes idle, so each burst is timed alone
	always_comb begin
		cnt_next = cnt_reg + 17'h1;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cnt_reg <= 17'h0;
			tx_cut <= 1'b0;
			timeout <= 1'b0;
		end else if (!tx_busy) begin
			cnt_reg <= 17'h0;
			tx_cut <= 1'b0;
			timeout <= 1'b0;
		end else if (!tx_cut && cnt_next == LIMIT_CYCLES[16:0]) begin
			cnt_reg <= cnt_next;
			tx_cut <= 1'b1;
			timeout <= 1'b1;
		end else begin
			cnt_reg <= tx_cut ? cnt_reg : cnt_next;
			timeout <= 1'b0;
		end
	end

	a_cut_at_limit: assert property (@(posedge clk) disable iff (!reset_n)
		tx_busy && !tx_cut && cnt_next == LIMIT_CYCLES[16:0] |=> tx_cut && timeout)
		else $error("watchdog did not cut at limit");
	a_cut_holds: assert property (@(posedge clk) disable iff (!reset_n)
		tx_cut && tx_busy |=> tx_cut && !timeout)
		else $error("cut released while still busy");
endmodule : ttp_tx_watchdog

// ---- ttp_host_model.sv ----
// host processor model driving the decoded register port
module ttp_host_model
	import ttp_pkg::*;
(
	input wire logic clk,
	output logic test_pin,
	output logic reg_access,
	output logic reg_write,
	output logic [7:0] reg_addr,
	output ttp_pkg::ttp_word_t reg_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// idle levels at time zero
	initial begin
		test_pin = 1'b0;
		reg_access = 1'b0;
		reg_write = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
	end
	// one access, held only for its taking edge
	task automatic acc(input logic w, input logic [7:0] a, input ttp_word_t d);
		@(posedge clk);
		reg_access <= 1'b1;
		reg_write <= w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_access <= 1'b0;
		reg_wdata <= ~d; // stale data must not look valid
	endtask : acc
	// pin, trigger write, optional stray access, clearing write
	task automatic arm(input ttp_word_t low, input int mid);
		@(posedge clk);
		test_pin <= 1'b1;
		repeat (3) @(posedge clk); // synchroniser needs two edges
		acc(1'b1, 8'h4e, 16'h8000 | low);
		test_pin <= 1'b0;
		if (mid == 1)
			acc(1'b0, 8'h4e, 16'h0000);
		if (mid == 2)
			acc(1'b1, 8'h10, 16'h0000);
		acc(1'b1, 8'h4e, low);
	endtask : arm
endmodule : ttp_host_model

// ---- tb_top.sv ----
// self-checking bench for the timeout protection block
`include "ttp_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ttp_pkg::*;
	// ==========================================================
	// signals
	localparam int WDT = 4100; // shortened so three words fit
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic test_pin, reg_access, reg_write, reg_rvalid, test_active;
	logic test_bus_b, test_word_strobe, lb_fail_set_a, lb_fail_set_b;
	logic terminal_flag_set, tfe;
	logic [7:0] reg_addr;
	ttp_word_t reg_wdata, reg_rdata, test_word_data;
	logic [1:0] start, busy, en;
	wire [1:0] cut;
	int n_errors = 0, n_compared = 0, cycles = 0, b;
	integer seed = 32'hb8699964;
	always #5 clk = ~clk;
	ttp_host_model i_ttp_host_model (.clk, .test_pin, .reg_access,
		.reg_write, .reg_addr, .reg_wdata);
	ttp_timeout_protect #(.WDT_CYCLES(WDT)) i_ttp_timeout_protect (.clk,
		.reset_n, .test_pin, .reg_access, .reg_write, .reg_addr,
		.reg_wdata, .reg_rdata, .reg_rvalid, .tx_start_a(start[0]),
		.tx_start_b(start[1]), .tx_busy_a(busy[0]), .tx_busy_b(busy[1]),
		.lb_fail_irq_en_a(en[0]), .lb_fail_irq_en_b(en[1]),
		.tx_cut_a(cut[0]), .tx_cut_b(cut[1]), .test_active, .test_bus_b,
		.test_word_strobe, .test_word_data, .lb_fail_set_a,
		.lb_fail_set_b, .terminal_flag_set);
	// ==========================================================
	// helpers
	function automatic ttp_word_t exp_reg(logic p, logic f);
		return {1'b0, p, `TTP_PART_ID_VAL, `TTP_REV_VAL, 4'h0, f, 3'h0};
	endfunction : exp_reg
	function automatic int exp_words();
		return ((WDT - 1) / 2000 + 1 > 35) ? 35 : (WDT - 1) / 2000 + 1;
	endfunction : exp_words
	task automatic chk(input string nm, input logic [15:0] e, g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rd(input ttp_word_t e);
		i_ttp_host_model.acc(1'b0, 8'h4e, 16'h0000);
		#1;
		chk("rvalid", 16'h0001, {15'h0, reg_rvalid});
		chk("rdata", e, reg_rdata);
	endtask : rd
	// one transmission held busy until the watchdog cuts it
	task automatic xmit(input int bb, input logic tst);
		int n, w;
		n = 0;
		w = 0;
		@(posedge clk);
		start[bb] <= 1'b1;
		busy[bb] <= 1'b1;
		@(posedge clk);
		start[bb] <= 1'b0;
		forever begin
			#1;
			if (cut[bb] === 1'b1 || n > 2 * WDT)
				break;
			if (n == 0)
				chk("active", tst, test_active);
			if (n == 0 && tst)
				chk("bus", bb, test_bus_b);
			if (tst && test_word_strobe === 1'b1) begin
				chk("word", w, test_word_data);
				w++;
			end
			n++;
			@(posedge clk);
		end
		chk("cut time", 1, n >= WDT - 2 && n <= WDT);
		chk("words", tst ? exp_words() : 0, w);
		@(posedge clk);
		#1;
		chk("lbfail", tst & en[bb], bb ? lb_fail_set_b : lb_fail_set_a);
		chk("tflag", tfe, terminal_flag_set);
		chk("ended", 0, test_active);
		@(posedge clk);
		busy[bb] <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("cut drop", 0, cut[bb]);
	endtask : xmit
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	// ==========================================================
	// hang guard, well above the four rounds of two transmissions
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			end_of_test();
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		start = 2'b00;
		busy = 2'b00;
		en = 2'b00;
		tfe = 1'b0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		rd(exp_reg(1'b0, 1'b0));
		// trigger written without the pin must not arm
		i_ttp_host_model.acc(1'b1, 8'h4e, 16'h8000);
		i_ttp_host_model.acc(1'b1, 8'h4e, 16'h0000);
		rd(exp_reg(1'b0, 1'b0));
		$display("test pinless done");
		// stray read or other access between the writes aborts
		for (int m = 1; m < 3; m++) begin
			i_ttp_host_model.arm(16'h0000, m);
			chk("trigger", 0, reg_rdata[15]);
			rd(exp_reg(1'b0, 1'b0));
			$display("test abort %0d done", m);
		end
		for (int i = 0; i < 4; i++) begin
			tfe = 1'($random(seed));
			b = $random(seed) & 1;
			en <= 2'($random(seed));
			i_ttp_host_model.arm({12'h0, tfe, 3'h0}, 0);
			rd(exp_reg(1'b1, tfe));
			xmit(b, 1'b1);
			rd(exp_reg(1'b0, tfe));
			xmit(1 - b, 1'b0);
			$display("test round %0d done", i);
		end
		end_of_test();
	end
endmodule : tb_top
